// file: hdl/ppp_consts.svh
// constants for the parallel nonvolatile programming port
`ifndef PPP_CONSTS_SVH
`define PPP_CONSTS_SVH
// command bytes
`define PPP_CMD_NOP 8'h00
`define PPP_CMD_WR_FLASH 8'h10
`define PPP_CMD_WR_EEPROM 8'h11
`define PPP_CMD_WR_FUSE 8'h40
`define PPP_CMD_WR_LOCK 8'h20
`define PPP_CMD_RD_FLASH 8'h02
`define PPP_CMD_RD_EEPROM 8'h03
`define PPP_CMD_RD_FUSELOCK 8'h04
`define PPP_CMD_CHIP_ERASE 8'h80
// memory geometry: flash 8k words, 64-word pages; eeprom 512 bytes, 4-byte pages
`define PPP_FLASH_AW 13
`define PPP_FLASH_PW 6
`define PPP_EE_AW 9
`define PPP_EE_PW 2
// reset values of fuses and lock byte (all erased)
`define PPP_FUSE_RST 8'hFF
`define PPP_LOCK_RST 8'hFF
// programming time in clock cycles, kept short for a model memory
`define PPP_PROG_CYC 16'h0040
// programmer pulse width: 250 ns at 20 ns clock, rounded up
`define PPP_PULSE_NS 250
`define PPP_PULSE_CYC ((`PPP_PULSE_NS + 19) / 20)
`endif

// file: hdl/ppp_dev.sv
// device end: command/address/data capture, page buffers, memories, fuses, lock
`timescale 1ns/10ps
`include "ppp_consts.svh"
module ppp_dev (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  ppp_if.dev pins,
  output logic [7:0] fuse_low,
  output logic [7:0] fuse_high,
  output logic [7:0] fuse_ext,
  output logic [7:0] lock_bits
);
  import ppp_pkg::*;

  // programming state machine, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } ppp_dst_t;

  ppp_dst_t state_ff; // current state
  logic [15:0] cnt_ff; // programming time left
  logic [7:0] cmd_ff; // last loaded command
  logic [15:0] addr_ff; // last loaded address
  logic [15:0] data_ff; // loaded data word
  logic [15:0] fpage_ff [0:63]; // flash page buffer
  logic [7:0] epage_ff [0:3]; // eeprom page buffer
  logic [63:0] fvalid_ff; // flash buffer words loaded
  logic [3:0] evalid_ff; // eeprom buffer bytes loaded
  logic [15:0] flash_ff [0:8191]; // flash array
  logic [7:0] eeprom_ff [0:511]; // eeprom array
  logic [7:0] fuse_low_ff; // low fuse byte
  logic [7:0] fuse_high_ff; // high fuse byte
  logic [7:0] fuse_ext_ff; // extended fuse byte
  logic [7:0] lock_ff; // lock byte
  logic [7:0] dout_ff; // read data register
  logic xclk_d_ff; // delayed load strobe, for edge detect
  logic pgl_d_ff; // delayed page latch
  logic wr_d_ff; // delayed write pulse
  logic wr_arm_ff; // write signals armed, cleared by nop
  logic wsel1_ff; // byte select one seen at the write pulse
  logic wsel2_ff; // byte select two seen at the write pulse
  logic xclk_rise; // load strobe rising edge
  logic pgl_rise; // page latch rising edge
  logic wr_fall; // write pulse falling edge
  logic [1:0] act; // action selection
  logic [7:0] din; // data bus as input
  logic lock_mode3; // both lock bits programmed
  logic [`PPP_FLASH_AW-1:0] faddr; // flash word address
  logic [`PPP_EE_AW-1:0] eaddr; // eeprom byte address

  assign act = {pins.strobe_action_sel_hi, pins.strobe_action_sel_lo};
  assign din = pins.data_bus;
  assign xclk_rise = pins.load_strobe_clock & ~xclk_d_ff;
  assign pgl_rise = pins.page_buffer_latch & ~pgl_d_ff;
  assign wr_fall = ~pins.wr_n & wr_d_ff;
  // word within page from low bits
  assign faddr = addr_ff[`PPP_FLASH_AW-1:0];
  assign eaddr = addr_ff[`PPP_EE_AW-1:0];
  assign lock_mode3 = ~lock_ff[0] & ~lock_ff[1];

  // edge detect registers; pins are synchronous to mclk
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      xclk_d_ff <= 1'b0;
      pgl_d_ff <= 1'b0;
      wr_d_ff <= 1'b1;
    end else if (clk_en) begin
      xclk_d_ff <= pins.load_strobe_clock;
      pgl_d_ff <= pins.page_buffer_latch;
      wr_d_ff <= pins.wr_n;
    end
  end

  // byte capture on load strobe; loads ignored while busy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_ff <= `PPP_CMD_NOP;
      addr_ff <= 16'h0000;
      data_ff <= 16'h0000;
      wr_arm_ff <= 1'b0;
    end else if (clk_en && xclk_rise && state_ff == ST_IDLE) begin
      case (act)
        2'h2: begin
          cmd_ff <= din;
          wr_arm_ff <= (din != `PPP_CMD_NOP);
        end
        2'h0: begin
          if (pins.byte_select_one) addr_ff[15:8] <= din;
          else addr_ff[7:0] <= din;
        end
        2'h1: begin
          if (pins.byte_select_one) data_ff[15:8] <= din;
          else data_ff[7:0] <= din;
        end
        default: begin
        end
      endcase
    end
  end
  // cmd_ff and addr_ff hold until reloaded

  // page buffers; latch only when armed and select one is high
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fvalid_ff <= 64'h0;
      evalid_ff <= 4'h0;
    end else if (clk_en) begin
      if (state_ff == ST_BUSY && cnt_ff == 16'h0001) begin
        fvalid_ff <= 64'h0;
        evalid_ff <= 4'h0;
      end else if (!wr_arm_ff) begin
        fvalid_ff <= 64'h0;
        evalid_ff <= 4'h0;
      end else if (pgl_rise && pins.byte_select_one && state_ff == ST_IDLE) begin
        if (cmd_ff == `PPP_CMD_WR_FLASH) begin
          fpage_ff[faddr[`PPP_FLASH_PW-1:0]] <= data_ff;
          fvalid_ff[faddr[`PPP_FLASH_PW-1:0]] <= 1'b1;
        end
        if (cmd_ff == `PPP_CMD_WR_EEPROM) begin
          epage_ff[eaddr[`PPP_EE_PW-1:0]] <= data_ff[7:0];
          evalid_ff[eaddr[`PPP_EE_PW-1:0]] <= 1'b1;
        end
      end
    end
  end

  // busy timer; write pulse starts an operation for any loaded command other than nop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 16'h0000;
      wsel1_ff <= 1'b0;
      wsel2_ff <= 1'b0;
    end else if (clk_en) begin
      case (state_ff)
        ST_IDLE: begin
          if (wr_fall && wr_arm_ff) begin
            state_ff <= ST_BUSY;
            cnt_ff <= `PPP_PROG_CYC;
            // selects kept from the pulse; host may drop them while busy
            wsel1_ff <= pins.byte_select_one;
            wsel2_ff <= pins.strobe_action_sel_hi;
          end
        end
        ST_BUSY: begin
          cnt_ff <= cnt_ff - 16'h0001;
          if (cnt_ff == 16'h0001) state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // commit at end of busy time; only loaded words change
  always_ff @(posedge mclk) begin
    if (clk_en && state_ff == ST_BUSY && cnt_ff == 16'h0001) begin
      // flash page write, page from high bits
      if (cmd_ff == `PPP_CMD_WR_FLASH) begin
        for (int i = 0; i < 64; i++) begin
          if (fvalid_ff[i])
            flash_ff[{faddr[`PPP_FLASH_AW-1:`PPP_FLASH_PW], i[`PPP_FLASH_PW-1:0]}] <= fpage_ff[i];
        end
      end
      if (cmd_ff == `PPP_CMD_WR_EEPROM) begin
        for (int j = 0; j < 4; j++) begin
          if (evalid_ff[j])
            eeprom_ff[{eaddr[`PPP_EE_AW-1:`PPP_EE_PW], j[`PPP_EE_PW-1:0]}] <= epage_ff[j];
        end
      end
    end
  end

  // fuse and lock bytes; chip erase and reset are the only ways lock bits rise
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fuse_low_ff <= `PPP_FUSE_RST;
      fuse_high_ff <= `PPP_FUSE_RST;
      fuse_ext_ff <= `PPP_FUSE_RST;
      lock_ff <= `PPP_LOCK_RST;
    end else if (clk_en && state_ff == ST_BUSY && cnt_ff == 16'h0001) begin
      if (cmd_ff == `PPP_CMD_WR_FUSE) begin
        if (wsel1_ff) fuse_high_ff <= data_ff[7:0];
        else if (wsel2_ff) fuse_ext_ff <= data_ff[7:0];
        else fuse_low_ff <= data_ff[7:0];
      end
      // no path back to one here
      if (cmd_ff == `PPP_CMD_WR_LOCK && !lock_mode3)
        lock_ff <= lock_ff & data_ff[7:0];
      if (cmd_ff == `PPP_CMD_CHIP_ERASE)
        lock_ff <= `PPP_LOCK_RST;
    end
  end

  // read path, registered; data output always from a flop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dout_ff <= 8'h00;
    end else if (clk_en) begin
      case (cmd_ff)
        // flash word byte by select one
        `PPP_CMD_RD_FLASH: dout_ff <= pins.byte_select_one ? flash_ff[faddr][15:8] :
          flash_ff[faddr][7:0];
        `PPP_CMD_RD_EEPROM: dout_ff <= eeprom_ff[eaddr];
        `PPP_CMD_RD_FUSELOCK: begin
          case ({pins.strobe_action_sel_hi, pins.byte_select_one})
            2'b00: dout_ff <= fuse_low_ff;
            2'b11: dout_ff <= fuse_high_ff;
            2'b10: dout_ff <= fuse_ext_ff;
            default: dout_ff <= lock_ff;
          endcase
        end
        default: dout_ff <= 8'h00;
      endcase
    end
  end

  // drive only while output enable low
  assign pins.data_dev_oe = ~pins.oe_n;
  assign pins.data_dev_out = dout_ff;
  assign pins.ready_busy_flag = (state_ff == ST_IDLE);
  assign fuse_low = fuse_low_ff;
  assign fuse_high = fuse_high_ff;
  assign fuse_ext = fuse_ext_ff;
  assign lock_bits = lock_ff;
endmodule : ppp_dev

// file: hdl/ppp_host.sv
// programmer end: turns user requests into pin sequences
`timescale 1ns/10ps
`include "ppp_consts.svh"
module ppp_host (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  ppp_if.host pins,
  input wire logic req_valid,
  output logic req_ready,
  input wire ppp_pkg::ppp_req_t req_kind,
  input wire logic req_sel_one,
  input wire logic req_sel_two,
  input wire logic [7:0] req_data,
  output logic rd_valid,
  output logic [7:0] rd_data
);
  import ppp_pkg::*;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_PULSE = 4'b0010,
    HS_GAP = 4'b0100,
    HS_WAIT = 4'b1000
  } ppp_hst_t;

  ppp_hst_t st_ff; // sequencer state
  ppp_req_t kind_ff; // request in progress
  logic [7:0] cnt_ff; // pulse/gap timer
  logic [1:0] act_ff; // action pins
  logic sel1_ff; // byte select one level
  logic sel2_ff; // byte select two
  logic [7:0] dout_ff; // bus drive value
  logic rd_valid_ff; // read result pulse
  logic [7:0] rd_data_ff; // read result
  logic [7:0] pw; // pulse width in cycles

  assign pw = 8'(`PPP_PULSE_CYC);

  // action pins set in the same cycle the strobe rises
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= HS_IDLE;
      kind_ff <= PPP_REQ_CMD;
      cnt_ff <= 8'h00;
      act_ff <= 2'h3;
      sel1_ff <= 1'b0;
      sel2_ff <= 1'b0;
      dout_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
      rd_data_ff <= 8'h00;
    end else if (clk_en) begin
      rd_valid_ff <= 1'b0;
      case (st_ff)
        HS_IDLE: begin
          if (req_valid) begin
            kind_ff <= req_kind;
            dout_ff <= req_data;
            sel1_ff <= req_sel_one;
            sel2_ff <= req_sel_two;
            cnt_ff <= pw;
            st_ff <= HS_PULSE;
            case (req_kind)
              PPP_REQ_CMD: act_ff <= 2'h2;
              PPP_REQ_ADDR: act_ff <= 2'h0;
              PPP_REQ_DATA: act_ff <= 2'h1;
              // select two rides on action bit 1
              default: act_ff <= {req_sel_two, 1'b0};
            endcase
          end
        end
        HS_PULSE: begin
          cnt_ff <= cnt_ff - 8'h01;
          if (cnt_ff == 8'h01) begin
            if (kind_ff == PPP_REQ_READ) begin
              rd_valid_ff <= 1'b1;
              rd_data_ff <= pins.data_bus;
            end
            cnt_ff <= pw;
            st_ff <= HS_GAP;
          end
        end
        HS_GAP: begin
          cnt_ff <= cnt_ff - 8'h01;
          if (cnt_ff == 8'h01) begin
            st_ff <= (kind_ff == PPP_REQ_WRITE) ? HS_WAIT : HS_IDLE;
            act_ff <= 2'h3;
          end
        end
        HS_WAIT: begin
          if (pins.ready_busy_flag) st_ff <= HS_IDLE;
        end
        default: st_ff <= HS_IDLE;
      endcase
    end
  end

  assign req_ready = (st_ff == HS_IDLE);
  assign pins.strobe_action_sel_hi = act_ff[1];
  assign pins.strobe_action_sel_lo = act_ff[0];
  assign pins.byte_select_one = sel1_ff;
  // page latch pulse with select one high
  assign pins.page_buffer_latch = (st_ff == HS_PULSE) && (kind_ff == PPP_REQ_LATCH);
  assign pins.load_strobe_clock = (st_ff == HS_PULSE) && (kind_ff == PPP_REQ_CMD ||
    kind_ff == PPP_REQ_ADDR || kind_ff == PPP_REQ_DATA);
  assign pins.wr_n = ~((st_ff == HS_PULSE) && (kind_ff == PPP_REQ_WRITE));
  assign pins.oe_n = ~((st_ff == HS_PULSE) && (kind_ff == PPP_REQ_READ));
  assign pins.data_host_out = dout_ff;
  // bus released while reading so the device can drive it
  assign pins.data_host_oe = (st_ff != HS_IDLE) && (kind_ff != PPP_REQ_READ);
  assign rd_valid = rd_valid_ff;
  assign rd_data = rd_data_ff;
endmodule : ppp_host

// file: hdl/ppp_if.sv
// pin bundle between the external programmer and the device port
`timescale 1ns/10ps
interface ppp_if;
  logic strobe_action_sel_hi; // action bit 1, doubles as byte_select_two
  logic strobe_action_sel_lo; // action bit 0
  logic byte_select_one; // byte select 1, separate from the page latch pin
  logic page_buffer_latch; // page load pulse
  logic load_strobe_clock; // positive pulse loads a byte
  logic wr_n; // write pulse, active low
  logic oe_n; // output enable, active low
  logic ready_busy_flag; // 1 ready, 0 busy
  logic [7:0] data_host_out; // bus value driven by the programmer
  logic data_host_oe; // programmer drives bus
  logic [7:0] data_dev_out; // bus value driven by the device
  logic data_dev_oe; // device drives bus
  logic [7:0] data_bus; // resolved bus level
  assign data_bus = data_dev_oe ? data_dev_out : (data_host_oe ? data_host_out : 8'hFF);
  modport dev (
    input strobe_action_sel_hi, strobe_action_sel_lo, byte_select_one, page_buffer_latch,
    input load_strobe_clock, wr_n, oe_n, data_bus,
    output ready_busy_flag, data_dev_out, data_dev_oe
  );
  modport host (
    output strobe_action_sel_hi, strobe_action_sel_lo, byte_select_one, page_buffer_latch,
    output load_strobe_clock, wr_n, oe_n, data_host_out, data_host_oe,
    input ready_busy_flag, data_bus
  );
endinterface : ppp_if

// file: hdl/ppp_pkg.sv
// types shared by both ends of the programming port
package ppp_pkg;
  // action select coding on the two action pins
  typedef enum logic [1:0] {
    PPP_ACT_ADDR = 2'h0,
    PPP_ACT_DATA = 2'h1,
    PPP_ACT_CMD = 2'h2,
    PPP_ACT_IDLE = 2'h3
  } ppp_act_t;
  // host request kinds
  typedef enum logic [2:0] {
    PPP_REQ_CMD = 3'h0,
    PPP_REQ_ADDR = 3'h1,
    PPP_REQ_DATA = 3'h2,
    PPP_REQ_LATCH = 3'h3,
    PPP_REQ_WRITE = 3'h4,
    PPP_REQ_READ = 3'h5
  } ppp_req_t;
endpackage : ppp_pkg

// file: testbench/ppp_monitor.sv
// pin-level checker for the programming port
`timescale 1ns/10ps
module ppp_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic strobe_action_sel_hi,
  input wire logic strobe_action_sel_lo,
  input wire logic byte_select_one,
  input wire logic page_buffer_latch,
  input wire logic load_strobe_clock,
  input wire logic wr_n,
  input wire logic oe_n,
  input wire logic ready_busy_flag,
  input wire logic data_host_oe,
  input wire logic data_dev_oe,
  input wire logic [7:0] data_bus
);
  // small slack around the 64-cycle busy time, edge detection may add one
  localparam int BUSY_MIN = 63;
  localparam int BUSY_MAX = 65;
  logic lsc_q_ff; // delayed copy of the load strobe
  logic [7:0] cmd_ff; // command the device last took
  logic [7:0] busy_cnt_ff; // cycles spent busy so far
  logic [1:0] act; // action pins as a pair
  assign act = {strobe_action_sel_hi, strobe_action_sel_lo};
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // strobe edge tracker, same sampling as the device
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lsc_q_ff <= 1'b0;
    end else begin
      lsc_q_ff <= load_strobe_clock;
    end
  end
  // command shadow, loads are ignored while busy
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_ff <= 8'h00;
    end else if (load_strobe_clock && !lsc_q_ff && act == 2'h2 && ready_busy_flag) begin
      cmd_ff <= data_bus;
    end
  end
  // busy length counter, cleared while ready
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_cnt_ff <= 8'h00;
    end else if (!ready_busy_flag) begin
      busy_cnt_ff <= busy_cnt_ff + 8'h01;
    end else begin
      busy_cnt_ff <= 8'h00;
    end
  end
  a_dev_drive_oe: assert property (data_dev_oe |-> !oe_n)
    else $error("device drives bus while output disabled");
  a_bus_no_fight: assert property (!(data_dev_oe && data_host_oe))
    else $error("both ends drive the data bus");
  a_busy_start: assert property (($fell(wr_n) && ready_busy_flag &&
      cmd_ff inside {8'h10, 8'h11, 8'h40}) |-> ##[1:2] !ready_busy_flag)
    else $error("write pulse did not make the device busy");
  a_busy_len: assert property ($rose(ready_busy_flag) |->
      (busy_cnt_ff >= BUSY_MIN && busy_cnt_ff <= BUSY_MAX))
    else $error("busy time off its length");
  a_busy_cap: assert property (busy_cnt_ff <= BUSY_MAX)
    else $error("busy lasted too long");
  a_nop_idle: assert property (($fell(wr_n) && ready_busy_flag && cmd_ff == 8'h00) |=>
      ready_busy_flag [*3])
    else $error("write after nop made device busy");
  a_wait_ready: assert property (!ready_busy_flag |-> !$rose(load_strobe_clock) &&
      !$fell(wr_n))
    else $error("programmer acted while device busy");
  a_cmd_sel_low: assert property (($rose(load_strobe_clock) && act == 2'h2) |->
      !byte_select_one)
    else $error("command load with byte select one high");
  a_latch_sel: assert property ($rose(page_buffer_latch) |-> byte_select_one)
    else $error("page latch with byte select one low");
  a_strobe_hold: assert property ($rose(load_strobe_clock) |=>
      (load_strobe_clock && $stable(act)) [*8])
    else $error("load strobe short or action changed");
  c_flash_write: cover property ($fell(wr_n) && cmd_ff == 8'h10);
  c_page_latch: cover property ($rose(page_buffer_latch));
  c_dev_read: cover property (!oe_n && data_dev_oe);
  c_busy_end: cover property ($rose(ready_busy_flag));
endmodule : ppp_monitor

// file: testbench/tb.sv
// self-checking bench joining programmer and device ends
`timescale 1ns/10ps
`include "ppp_consts.svh"
`define CHK(g, e) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    err_count++; \
    $display("BAD %0t got %h exp %h", $time, g, e); \
  end \
end
module tb;
  import ppp_pkg::*;
  logic mclk; // system clock
  logic rst; // async reset
  logic clk_en; // run enable of both ends
  logic req_valid; // request handshake
  logic req_ready;
  ppp_req_t req_kind;
  logic req_sel_one;
  logic req_sel_two;
  logic [7:0] req_data;
  logic rd_valid; // read answer pulse
  logic [7:0] rd_data;
  logic [7:0] fuse_low, fuse_high, fuse_ext, lock_bits;
  logic [7:0] last_rd; // last byte a read returned
  logic [15:0] fl_exp [int]; // expected flash words by address
  int err_count;
  int num_checks;
  ppp_if ppp_if_i ();
  ppp_host ppp_host_i (.mclk(mclk), .rst(rst), .clk_en(clk_en), .pins(ppp_if_i),
    .req_valid(req_valid), .req_ready(req_ready), .req_kind(req_kind),
    .req_sel_one(req_sel_one), .req_sel_two(req_sel_two), .req_data(req_data),
    .rd_valid(rd_valid), .rd_data(rd_data));
  ppp_dev ppp_dev_i (.mclk(mclk), .rst(rst), .clk_en(clk_en), .pins(ppp_if_i),
    .fuse_low(fuse_low), .fuse_high(fuse_high), .fuse_ext(fuse_ext), .lock_bits(lock_bits));
  ppp_monitor ppp_monitor_i (.mclk(mclk), .rst(rst),
    .strobe_action_sel_hi(ppp_if_i.strobe_action_sel_hi),
    .strobe_action_sel_lo(ppp_if_i.strobe_action_sel_lo),
    .byte_select_one(ppp_if_i.byte_select_one), .page_buffer_latch(ppp_if_i.page_buffer_latch),
    .load_strobe_clock(ppp_if_i.load_strobe_clock), .wr_n(ppp_if_i.wr_n), .oe_n(ppp_if_i.oe_n),
    .ready_busy_flag(ppp_if_i.ready_busy_flag), .data_host_oe(ppp_if_i.data_host_oe),
    .data_dev_oe(ppp_if_i.data_dev_oe), .data_bus(ppp_if_i.data_bus));
  // lock update: mode 3 freezes, otherwise bits only program
  function automatic logic [7:0] exp_lock(input logic [7:0] old, input logic [7:0] d);
    return (old[1:0] == 2'h0) ? old : (old & d);
  endfunction : exp_lock
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // one request held until taken, then wait for the host to return idle
  task automatic do_req(input ppp_req_t k, input logic s1, input logic s2,
      input logic [7:0] d);
    int n;
    n = 0;
    // a read that never answers must not pass on a stale byte
    if (k == PPP_REQ_READ) last_rd = 8'hXX;
    req_kind = k;
    req_sel_one = s1;
    req_sel_two = s2;
    req_data = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 500) begin
      @(posedge mclk);
      #1;
      n++;
    end
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    // a write stays non-idle until ready returns, so this also waits out busy
    while (req_ready !== 1'b1 && n < 500) begin
      @(posedge mclk);
      #1;
      if (rd_valid === 1'b1) begin
        last_rd = rd_data;
      end
      n++;
    end
    if (n >= 500) begin
      err_count++;
      $display("BAD %0t request never finished", $time);
      final_report();
    end
  endtask : do_req
  // address both bytes, high first
  task automatic set_addr(input logic [15:0] a);
    do_req(PPP_REQ_ADDR, 1'b1, 1'b0, a[15:8]);
    do_req(PPP_REQ_ADDR, 1'b0, 1'b0, a[7:0]);
  endtask : set_addr
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin : main
    logic [12:0] base;
    logic [12:0] a;
    logic [15:0] w;
    logic [8:0] ea;
    logic [7:0] d;
    logic [7:0] lk;
    logic [7:0] bytes [4];
    int offs [4];
    rst = 1'b1;
    clk_en = 1'b1;
    req_valid = 1'b0;
    req_kind = PPP_REQ_CMD;
    req_sel_one = 1'b0;
    req_sel_two = 1'b0;
    req_data = 8'h00;
    last_rd = 8'h00;
    err_count = 0;
    num_checks = 0;
    void'($urandom(32'h06CC1806));
    repeat (16) @(posedge mclk);
    #1 rst = 1'b0;
    `CHK(ppp_if_i.ready_busy_flag, 1'b1)
    `CHK({fuse_low, fuse_high, fuse_ext, lock_bits}, 32'hFFFFFFFF)
    $display("test reset done");
    // two pages differing in low byte bit 6, edge words included
    offs = '{0, 63, $urandom_range(1, 31), $urandom_range(32, 62)};
    base = 13'($urandom) & 13'h1FC0;
    do_req(PPP_REQ_CMD, 1'b0, 1'b0, `PPP_CMD_WR_FLASH);
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 4; i++) begin
        a = (base ^ (13'(j) << 6)) | 13'(offs[i]);
        w = 16'($urandom);
        fl_exp[a] = w;
        set_addr({3'h0, a});
        do_req(PPP_REQ_DATA, 1'b0, 1'b0, w[7:0]);
        do_req(PPP_REQ_DATA, 1'b1, 1'b0, w[15:8]);
        do_req(PPP_REQ_LATCH, 1'b1, 1'b0, 8'h00);
      end
      do_req(PPP_REQ_WRITE, 1'b0, 1'b0, 8'h00);
    end
    do_req(PPP_REQ_CMD, 1'b0, 1'b0, `PPP_CMD_RD_FLASH);
    foreach (fl_exp[k]) begin
      set_addr(16'(k));
      do_req(PPP_REQ_READ, 1'b0, 1'b0, 8'h00);
      `CHK(last_rd, fl_exp[k][7:0])
      do_req(PPP_REQ_READ, 1'b1, 1'b0, 8'h00);
      `CHK(last_rd, fl_exp[k][15:8])
    end
    $display("test flash done");
    // nop between latch and write discards the page
    do_req(PPP_REQ_CMD, 1'b0, 1'b0, `PPP_CMD_WR_FLASH);
    set_addr({3'h0, base});
    do_req(PPP_REQ_DATA, 1'b0, 1'b0, ~fl_exp[base][7:0]);
    do_req(PPP_REQ_LATCH, 1'b1, 1'b0, 8'h00);
    do_req(PPP_REQ_CMD, 1'b0, 1'b0, `PPP_CMD_NOP);
    do_req(PPP_REQ_WRITE, 1'b0, 1'b0, 8'h00);
    do_req(PPP_REQ_CMD, 1'b0, 1'b0, `PPP_CMD_RD_FLASH);
    do_req(PPP_REQ_READ, 1'b0, 1'b0, 8'h00);
    `CHK(last_rd, fl_exp[base][7:0])
    $display("test nop done");
    // eeprom page fill and read back
    ea = 9'($urandom) & 9'h1FC;
    do_req(PPP_REQ_CMD, 1'b0, 1'b0, `PPP_CMD_WR_EEPROM);
    for (int i = 0; i < 4; i++) begin
      bytes[i] = 8'($urandom);
      set_addr({7'h00, ea | 9'(i)});
      do_req(PPP_REQ_DATA, 1'b0, 1'b0, bytes[i]);
      do_req(PPP_REQ_LATCH, 1'b1, 1'b0, 8'h00);
    end
    do_req(PPP_REQ_WRITE, 1'b0, 1'b0, 8'h00);
    do_req(PPP_REQ_CMD, 1'b0, 1'b0, `PPP_CMD_RD_EEPROM);
    for (int i = 0; i < 4; i++) begin
      do_req(PPP_REQ_ADDR, 1'b0, 1'b0, ea[7:0] | 8'(i));
      do_req(PPP_REQ_READ, 1'b0, 1'b0, 8'h00);
      `CHK(last_rd, bytes[i])
    end
    $display("test eeprom done");
    // low, high and extended fuse by select pins
    do_req(PPP_REQ_CMD, 1'b0, 1'b0, `PPP_CMD_WR_FUSE);
    for (int i = 0; i < 3; i++) begin
      bytes[i] = 8'($urandom);
      do_req(PPP_REQ_DATA, 1'b0, 1'b0, bytes[i]);
      do_req(PPP_REQ_WRITE, i == 1, i == 2, 8'h00);
    end
    `CHK({fuse_low, fuse_high, fuse_ext}, {bytes[0], bytes[1], bytes[2]})
    do_req(PPP_REQ_CMD, 1'b0, 1'b0, `PPP_CMD_RD_FUSELOCK);
    for (int i = 0; i < 3; i++) begin
      do_req(PPP_REQ_READ, i == 1, i != 0, 8'h00);
      `CHK(last_rd, bytes[i])
    end
    $display("test fuse done");
    // program, reach mode 3, then a refused rewrite
    lk = 8'hFF;
    bytes[0] = 8'($urandom) | 8'h02;
    bytes[1] = 8'($urandom) & 8'hFC;
    bytes[2] = 8'h00;
    do_req(PPP_REQ_CMD, 1'b0, 1'b0, `PPP_CMD_WR_LOCK);
    for (int i = 0; i < 3; i++) begin
      do_req(PPP_REQ_DATA, 1'b0, 1'b0, bytes[i]);
      do_req(PPP_REQ_WRITE, 1'b0, 1'b0, 8'h00);
      lk = exp_lock(lk, bytes[i]);
      `CHK(lock_bits, lk)
    end
    do_req(PPP_REQ_CMD, 1'b0, 1'b0, `PPP_CMD_RD_FUSELOCK);
    do_req(PPP_REQ_READ, 1'b1, 1'b0, 8'h00);
    `CHK(last_rd, lk)
    do_req(PPP_REQ_CMD, 1'b0, 1'b0, `PPP_CMD_CHIP_ERASE);
    do_req(PPP_REQ_WRITE, 1'b0, 1'b0, 8'h00);
    `CHK(lock_bits, 8'hFF)
    $display("test lock done");
    // clock enable low freezes both ends, a pending request is not taken
    clk_en = 1'b0;
    req_kind = PPP_REQ_CMD;
    req_valid = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    `CHK({req_ready, ppp_if_i.load_strobe_clock}, 2'b10)
    req_valid = 1'b0;
    clk_en = 1'b1;
    $display("test freeze done");
    final_report();
  end
endmodule : tb
